// [shared/t1c_pkg.sv]
// Constants for the 16-bit timer one control block: register map, fields, codes.
// Assumes a single 100 MHz system clock that is also the oscillator clock.
`default_nettype none
package t1c_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses on the Avalon-MM slave)
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_CONTROL = 4'h0;
  localparam logic [3:0] ADDR_COUNT = 4'h4;
  localparam logic [3:0] ADDR_STATUS = 4'h8;

  // ----------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------
  localparam int RUN_BIT = 0;
  localparam int SYNC_BYPASS_BIT = 2;
  localparam int PRESCALE_LSB = 4;
  localparam int CLKSEL_LSB = 6;
  localparam logic [7:0] CONTROL_MASK = 8'hF5;
  localparam logic [7:0] CONTROL_RESET = 8'h00;

  // ----------------------------------------------------------------
  // Status register fields
  // ----------------------------------------------------------------
  localparam int STAT_TOGGLE_BIT = 0;
  localparam int STAT_PIN_BIT = 1;
  localparam int STAT_ASYNC_BIT = 2;

  // ----------------------------------------------------------------
  // Count clock sources
  // ----------------------------------------------------------------
  localparam logic [1:0] SRC_INSTR = 2'h0;
  localparam logic [1:0] SRC_SYSTEM = 2'h1;
  localparam logic [1:0] SRC_EXTERNAL = 2'h2;

  // ----------------------------------------------------------------
  // Prescale codes and widths
  // ----------------------------------------------------------------
  localparam logic [1:0] PRE_DIV1 = 2'h0;
  localparam logic [1:0] PRE_DIV2 = 2'h1;
  localparam logic [1:0] PRE_DIV4 = 2'h2;
  localparam logic [1:0] PRE_DIV8 = 2'h3;
  localparam int PRE_WIDTH = 3;

  // ----------------------------------------------------------------
  // Timing: instruction clock is the oscillator divided by four
  // ----------------------------------------------------------------
  localparam int INSTR_DIV = 4;
  localparam logic [1:0] INSTR_PHASE_LAST = 2'(INSTR_DIV - 1);
  localparam int COUNT_WIDTH = 16;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;

  // ----------------------------------------------------------------
  // Avalon-MM response codes
  // ----------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECODEERROR = 2'h3;

endpackage : t1c_pkg
`default_nettype wire

// [core/t1c_prescaler.sv]
// Input prescaler: passes one of every 1, 2, 4 or 8 input ticks.
// Assumes ticks are single-cycle pulses on the system clock.
`timescale 1ns/10ps
`default_nettype none
module t1c_prescaler (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Control
  input wire logic clear,
  input wire logic [1:0] select,
  // Ticks
  input wire logic tickIn,
  output logic tickOut
);

  logic [t1c_pkg::PRE_WIDTH-1:0] preCount_r;
  logic [t1c_pkg::PRE_WIDTH-1:0] mask;

  // ----------------------------------------------------------------
  // Division mask from the select code
  // ----------------------------------------------------------------
  always_comb begin
    unique case (select)
      t1c_pkg::PRE_DIV1: mask = 3'h0;
      t1c_pkg::PRE_DIV2: mask = 3'h1;
      t1c_pkg::PRE_DIV4: mask = 3'h3;
      t1c_pkg::PRE_DIV8: mask = 3'h7;
    endcase
  end

  assign tickOut = tickIn && ((preCount_r & mask) == mask);

  always_ff @(posedge clock) begin
    if (sys_rst || clear) begin
      preCount_r <= '0;
    end else if (tickIn) begin
      preCount_r <= preCount_r + 3'h1;
    end
  end

endmodule : t1c_prescaler
`default_nettype wire

// [core/t1c_timer.sv]
// Timer one: control register, clock source selection, prescaler and 16-bit counter.
// Assumes an Avalon-MM master on the system clock and asynchronous count and gate pins.
//
// Operation
// - Source code 10 counts rising edges of the external count pin.
// - Source code 01 counts every system oscillator clock.
// - Source code 00 counts the instruction clock, oscillator divided by four.
// - Prescale field divides the selected clock by 1, 2, 4 or 8.
// - Sync bypass set passes the pin-synchronised external clock without the extra system clock resync stage.
// - Sync bypass clear resynchronises the external clock to the system clock.
// - Run bit, control bit zero, enables counting.
// - Clearing run stops the timer and clears the gate toggle flip-flop.
// - During sleep counting continues only in asynchronous external counter mode.
`timescale 1ns/10ps
`default_nettype none
module t1c_timer (
  // Clock and resets
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic warmRst,
  // Avalon-MM slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [1:0] avs_response,
  // Pins
  input wire logic ext_count_pin,
  input wire logic gatePin,
  // Power state
  input wire logic sleepMode,
  // Timer state
  output logic [15:0] countValue,
  output logic rollover,
  output logic timerRunning,
  output logic gateToggle
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [7:0] control_r;
  logic [15:0] count_r;
  logic waitReq_r;
  logic [31:0] readData_r;
  logic [1:0] response_r;
  logic rollover_r;
  logic gateToggle_r;
  logic extSync1_r;
  logic extSync2_r;
  logic extPrev_r;
  logic gateSync1_r;
  logic gateSync2_r;
  logic gatePrev_r;
  logic [1:0] phase_r;
  logic resyncTick_r;
  logic accept;
  logic writeFire;
  logic controlWrite;
  logic countWrite;
  logic runBit;
  logic syncBypass;
  logic [1:0] clkSel;
  logic [1:0] preSel;
  logic asyncMode;
  logic runAllowed;
  logic extRise;
  logic gateRise;
  logic instrTick;
  logic srcTick;
  logic preTick;
  logic countTick;
  logic preClear;

  // Address decode, shared by read mux and write strobes
  function automatic logic isAddr(input logic [3:0] addr, input logic [3:0] target);
    isAddr = (addr == target);
  endfunction : isAddr

  // ----------------------------------------------------------------
  // Field views
  // ----------------------------------------------------------------
  assign runBit = control_r[t1c_pkg::RUN_BIT];
  assign syncBypass = control_r[t1c_pkg::SYNC_BYPASS_BIT];
  assign clkSel = control_r[t1c_pkg::CLKSEL_LSB +: 2];
  assign preSel = control_r[t1c_pkg::PRESCALE_LSB +: 2];
  assign asyncMode = (clkSel == t1c_pkg::SRC_EXTERNAL) && syncBypass;
  assign runAllowed = runBit && (!sleepMode || asyncMode);

  // ----------------------------------------------------------------
  // Avalon-MM slave
  // ----------------------------------------------------------------
  // One wait cycle per access; the request completes on the second edge after it appears.
  assign accept = (avs_read || avs_write) && waitReq_r;
  assign writeFire = avs_write && !waitReq_r;
  assign controlWrite = writeFire && isAddr(avs_address, t1c_pkg::ADDR_CONTROL);
  assign countWrite = writeFire && isAddr(avs_address, t1c_pkg::ADDR_COUNT);

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      waitReq_r <= 1'b1;
    end else begin
      waitReq_r <= !accept;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      readData_r <= 32'h0000_0000;
      response_r <= t1c_pkg::RESP_OKAY;
    end else if (accept) begin
      response_r <= t1c_pkg::RESP_OKAY;
      readData_r <= 32'h0000_0000;
      if (isAddr(avs_address, t1c_pkg::ADDR_CONTROL)) begin
        readData_r[7:0] <= control_r;
      end else if (isAddr(avs_address, t1c_pkg::ADDR_COUNT)) begin
        readData_r[15:0] <= count_r;
      end else if (isAddr(avs_address, t1c_pkg::ADDR_STATUS)) begin
        readData_r[t1c_pkg::STAT_TOGGLE_BIT] <= gateToggle_r;
        readData_r[t1c_pkg::STAT_PIN_BIT] <= extSync2_r;
        readData_r[t1c_pkg::STAT_ASYNC_BIT] <= asyncMode;
      end else begin
        response_r <= t1c_pkg::RESP_DECODEERROR;
      end
    end
  end

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  // only power-on reset clears control
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      control_r <= t1c_pkg::CONTROL_RESET;
    end else if (controlWrite) begin
      control_r <= avs_writedata[7:0] & t1c_pkg::CONTROL_MASK;
    end
  end

  // ----------------------------------------------------------------
  // Pin synchronisers and edge detect
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      extSync1_r <= 1'b0;
      extSync2_r <= 1'b0;
      extPrev_r <= 1'b0;
      gateSync1_r <= 1'b0;
      gateSync2_r <= 1'b0;
      gatePrev_r <= 1'b0;
    end else begin
      extSync1_r <= ext_count_pin;
      extSync2_r <= extSync1_r;
      extPrev_r <= extSync2_r;
      gateSync1_r <= gatePin;
      gateSync2_r <= gateSync1_r;
      gatePrev_r <= gateSync2_r;
    end
  end

  assign extRise = extSync2_r && !extPrev_r;
  assign gateRise = gateSync2_r && !gatePrev_r;

  // ----------------------------------------------------------------
  // Instruction clock phase
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (sys_rst || warmRst) begin
      phase_r <= 2'h0;
    end else begin
      phase_r <= phase_r + 2'h1;
    end
  end

  // one tick per four oscillator clocks
  assign instrTick = (phase_r == t1c_pkg::INSTR_PHASE_LAST);

  // ----------------------------------------------------------------
  // Source selection
  // ----------------------------------------------------------------
  always_comb begin
    srcTick = 1'b0;
    unique case (clkSel)
      t1c_pkg::SRC_INSTR: srcTick = instrTick;
      t1c_pkg::SRC_SYSTEM: srcTick = 1'b1;
      t1c_pkg::SRC_EXTERNAL: srcTick = extRise;
      // Undefined encoding: holds the count
      default: srcTick = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Prescaler
  // ----------------------------------------------------------------
  // Cleared whenever stopped or the count is rewritten, so a fresh start is exact
  assign preClear = warmRst || !runBit || countWrite;

  t1c_prescaler prescaler (
    .clock(clock),
    .sys_rst(sys_rst),
    .clear(preClear),
    .select(preSel),
    .tickIn(srcTick && runAllowed),
    .tickOut(preTick)
  );

  // extra resync stage on the system clock
  always_ff @(posedge clock) begin
    if (sys_rst || warmRst) begin
      resyncTick_r <= 1'b0;
    end else begin
      resyncTick_r <= preTick && runAllowed;
    end
  end

  always_comb begin
    if ((clkSel == t1c_pkg::SRC_EXTERNAL) && !syncBypass) begin
      countTick = resyncTick_r && runAllowed;
    end else begin
      countTick = preTick;
    end
  end

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (sys_rst || warmRst) begin
      count_r <= t1c_pkg::COUNT_RESET;
      rollover_r <= 1'b0;
    end else if (countWrite) begin
      count_r <= avs_writedata[15:0];
      rollover_r <= 1'b0;
    end else if (runBit && countTick) begin
      count_r <= count_r + 16'h0001;
      rollover_r <= (count_r == t1c_pkg::COUNT_MAX);
    end else begin
      rollover_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Gate toggle flip-flop
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (sys_rst || warmRst) begin
      gateToggle_r <= 1'b0;
    end else if (!runBit) begin
      gateToggle_r <= 1'b0;
    end else if (gateRise) begin
      gateToggle_r <= !gateToggle_r;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign avs_readdata = readData_r;
  assign avs_waitrequest = waitReq_r;
  assign avs_response = response_r;
  assign countValue = count_r;
  assign rollover = rollover_r;
  assign timerRunning = control_r[t1c_pkg::RUN_BIT];
  assign gateToggle = gateToggle_r;

endmodule : t1c_timer
`default_nettype wire

// [bench/t1c_pin_source.sv]
// External clock source model that drives the count pin in bursts.
// Assumes start is a one-cycle request and the pin rests low between bursts.
`timescale 1ns/10ps
`default_nettype none
module t1c_pin_source (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Control
  input wire logic start,
  input wire logic slow,
  input wire logic [7:0] pulses,
  // Pin side
  output logic ext_count_pin,
  output logic busy
);
  logic [7:0] leftCount_r;
  logic [2:0] halfPhase_r;
  // ----------------------------------------------------------------
  // Half period of 3 or 6 clocks, both levels above two clocks
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      leftCount_r <= 8'h00;
      halfPhase_r <= 3'h0;
      ext_count_pin <= 1'h0;
    end else if (start && leftCount_r == 8'h00) begin
      leftCount_r <= pulses;
      halfPhase_r <= 3'h0;
    end else if (leftCount_r != 8'h00) begin
      halfPhase_r <= halfPhase_r + 3'h1;
      if (halfPhase_r == (slow ? 3'h5 : 3'h2)) begin
        halfPhase_r <= 3'h0;
        ext_count_pin <= !ext_count_pin;
        if (ext_count_pin) begin
          leftCount_r <= leftCount_r - 8'h01;
        end
      end
    end
  end
  assign busy = leftCount_r != 8'h00;
endmodule : t1c_pin_source
`default_nettype wire

// [bench/t1c_timer_chk.sv]
// Concurrent checks on the ports of the timer one block.
// Assumes a slave that answers every access after exactly one wait cycle.
`timescale 1ns/10ps
`default_nettype none
module t1c_timer_chk (
  // Clock and resets
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic warmRst,
  // Bus
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic [1:0] avs_response,
  // Pins and state
  input wire logic ext_count_pin,
  input wire logic sleepMode,
  input wire logic [15:0] countValue,
  input wire logic timerRunning,
  input wire logic gateToggle
);
  // ----------------------------------------------------------------
  // Shadow of the control register
  // ----------------------------------------------------------------
  logic [7:0] ctl_r;
  logic done, wrCtl, wrCnt, mapped, asyncM;
  assign done = (avs_read || avs_write) && !avs_waitrequest;
  assign wrCtl = done && avs_write && avs_address == t1c_pkg::ADDR_CONTROL;
  assign wrCnt = done && avs_write && avs_address == t1c_pkg::ADDR_COUNT;
  assign mapped = avs_address inside {t1c_pkg::ADDR_CONTROL, t1c_pkg::ADDR_COUNT,
    t1c_pkg::ADDR_STATUS};
  assign asyncM = ctl_r[t1c_pkg::CLKSEL_LSB +: 2] == t1c_pkg::SRC_EXTERNAL &&
    ctl_r[t1c_pkg::SYNC_BYPASS_BIT];
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ctl_r <= t1c_pkg::CONTROL_RESET;
    end else if (wrCtl) begin
      ctl_r <= avs_writedata[7:0] & t1c_pkg::CONTROL_MASK;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  sequence bump;
    countValue == $past(countValue) + 16'h0001;
  endsequence
  AST_BUS_ONE: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest ##1 avs_waitrequest) else $error("bus wait not one cycle");
  AST_RESP: assert property (done |-> avs_response == (mapped ? t1c_pkg::RESP_OKAY :
    t1c_pkg::RESP_DECODEERROR) && (mapped || avs_write || avs_readdata == 32'h0000_0000))
    else $error("bad response code");
  AST_CTL_READ: assert property (done && avs_read && avs_address == t1c_pkg::ADDR_CONTROL
    |-> avs_readdata == {24'h00_0000, ctl_r}) else $error("control readback wrong");
  AST_RUN_LEVEL: assert property (ctl_r[0] == $past(ctl_r[0])
    |-> timerRunning == ctl_r[0]) else $error("run output differs from control");
  AST_RUN_HOLD: assert property (!timerRunning && !wrCnt && !warmRst ##1 !timerRunning
    |-> $stable(countValue)) else $error("count moved while stopped");
  AST_TOGGLE_CLR: assert property (!timerRunning ##1 !timerRunning |-> !gateToggle)
    else $error("toggle not cleared while stopped");
  AST_SLEEP_HOLD: assert property (sleepMode && !asyncM && !wrCnt && !warmRst ##1 sleepMode
    |-> $stable(countValue)) else $error("count moved in sleep");
  AST_BYPASS_LAT: assert property (ctl_r == 8'h85 && $rose(ext_count_pin)
    |-> ##2 $stable(countValue) ##1 bump) else $error("bypass latency wrong");
  AST_SYNC_LAT: assert property (ctl_r == 8'h81 && $rose(ext_count_pin)
    |-> ##3 $stable(countValue) ##1 bump) else $error("sync latency wrong");
endmodule : t1c_timer_chk
bind t1c_timer t1c_timer_chk t1c_timer_chk_inst (.clock(clock), .sys_rst(sys_rst),
  .warmRst(warmRst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .avs_response(avs_response),
  .ext_count_pin(ext_count_pin), .sleepMode(sleepMode), .countValue(countValue),
  .timerRunning(timerRunning), .gateToggle(gateToggle));
`default_nettype wire

// [bench/test_timer1_control_register.sv]
// Self-checking bench for the timer one block with an external pin source.
// Assumes one 100 MHz clock and a slave with one wait cycle per access.
`timescale 1ns/10ps
`default_nettype none
module test_timer1_control_register;
  logic clock = 1'h0, sys_rst = 1'h1, warmRst = 1'h0, avs_read = 1'h0, avs_write = 1'h0;
  logic gatePin = 1'h0, sleepMode = 1'h0, start = 1'h0, slow = 1'h0;
  logic [3:0] avs_address = 4'h0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [31:0] avs_readdata, rd, a;
  logic [1:0] avs_response, rs;
  logic avs_waitrequest, ext_count_pin, busy, rollover, timerRunning, gateToggle;
  logic [7:0] pulses = 8'h00;
  logic [15:0] countValue, gain;
  int bad_count = 0;
  int n_checks = 0;
  // Control written, sleep level, count gained over 96 cycles
  logic [7:0] rowCtl [11] = '{8'h01, 8'h11, 8'h21, 8'h31, 8'h41, 8'h51, 8'h61, 8'h71,
    8'hFF, 8'h40, 8'h41};
  logic [10:0] rowSlp = 11'h400;
  logic [15:0] rowGain [11] = '{16'h0018, 16'h000C, 16'h0006, 16'h0003, 16'h0060,
    16'h0030, 16'h0018, 16'h000C, 16'h0000, 16'h0000, 16'h0000};
  // Pin rows: control, pulses sent, sleep and slow source
  logic [7:0] extCtl [4] = '{8'h81, 8'h85, 8'hA5, 8'h85};
  logic [7:0] extNum [4] = '{8'h05, 8'h05, 8'h08, 8'h04};
  logic [3:0] extSlp = 4'h8;
  logic [3:0] extSlow = 4'h2;
  t1c_timer t1c_timer_inst (.clock(clock), .sys_rst(sys_rst), .warmRst(warmRst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .avs_response(avs_response),
    .ext_count_pin(ext_count_pin), .gatePin(gatePin), .sleepMode(sleepMode),
    .countValue(countValue), .rollover(rollover), .timerRunning(timerRunning),
    .gateToggle(gateToggle));
  t1c_pin_source t1c_pin_source_inst (.clock(clock), .sys_rst(sys_rst), .start(start),
    .slow(slow), .pulses(pulses), .ext_count_pin(ext_count_pin), .busy(busy));
  always #5 clock = ~clock;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [3:0] ad, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clock);
    avs_read <= !w;
    avs_write <= w;
    avs_address <= ad;
    avs_writedata <= wd;
    do begin
      @(posedge clock);
      n++;
    end while (avs_waitrequest !== 1'h0 && n < 20);
    chk(32'(avs_waitrequest), 32'h0000_0000);
    rd = avs_readdata;
    rs = avs_response;
    avs_read <= 1'h0;
    avs_write <= 1'h0;
  endtask : bus
  task automatic sendPins(input logic [7:0] num);
    int n;
    n = 0;
    @(posedge clock);
    pulses <= num;
    start <= 1'h1;
    @(posedge clock);
    start <= 1'h0;
    do begin
      @(posedge clock);
      n++;
    end while (busy && n < 400);
    chk(32'(busy), 32'h0000_0000);
    // Lets the pin synchroniser drain
    repeat (6) @(posedge clock);
  endtask : sendPins
  task automatic report_and_stop;
    $display("Checks %0d, mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    #200000;
    bad_count++;
    report_and_stop();
  end
  initial begin
    int n;
    repeat (16) @(posedge clock);
    sys_rst <= 1'h0;
    bus(1'h0, t1c_pkg::ADDR_CONTROL, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    for (int i = 0; i < 11; i++) begin
      sleepMode <= rowSlp[i];
      bus(1'h1, t1c_pkg::ADDR_CONTROL, {24'hFF_FFFF, rowCtl[i]});
      bus(1'h0, t1c_pkg::ADDR_CONTROL, 32'h0000_0000);
      chk(rd, {24'h00_0000, rowCtl[i] & t1c_pkg::CONTROL_MASK});
      bus(1'h0, t1c_pkg::ADDR_COUNT, 32'h0000_0000);
      a = rd;
      // Span between the two samples is 96 cycles
      repeat (93) @(posedge clock);
      bus(1'h0, t1c_pkg::ADDR_COUNT, 32'h0000_0000);
      gain = rd[15:0] - a[15:0];
      chk(32'(gain), 32'(rowGain[i]));
    end
    for (int i = 0; i < 4; i++) begin
      sleepMode <= extSlp[i];
      slow <= extSlow[i];
      bus(1'h1, t1c_pkg::ADDR_CONTROL, {24'h00_0000, extCtl[i]});
      bus(1'h1, t1c_pkg::ADDR_COUNT, 32'h0000_0000);
      sendPins(extNum[i]);
      chk(32'(countValue), {24'h00_0000, extNum[i] >> extCtl[i][5:4]});
    end
    bus(1'h0, t1c_pkg::ADDR_STATUS, 32'h0000_0000);
    chk(rd, 32'h0000_0001 << t1c_pkg::STAT_ASYNC_BIT);
    sleepMode <= 1'h0;
    bus(1'h1, t1c_pkg::ADDR_CONTROL, 32'h0000_0041);
    warmRst <= 1'h1;
    @(posedge clock);
    warmRst <= 1'h0;
    #1 chk(32'(countValue), 32'h0000_0000);
    bus(1'h0, t1c_pkg::ADDR_CONTROL, 32'h0000_0000);
    chk(rd, 32'h0000_0041);
    gatePin <= 1'h1;
    repeat (6) @(posedge clock);
    chk(32'(gateToggle), 32'h0000_0001);
    gatePin <= 1'h0;
    bus(1'h1, t1c_pkg::ADDR_CONTROL, 32'h0000_0040);
    repeat (3) @(posedge clock);
    chk(32'(gateToggle), 32'h0000_0000);
    chk(32'(timerRunning), 32'h0000_0000);
    bus(1'h1, t1c_pkg::ADDR_CONTROL, 32'h0000_0041);
    bus(1'h1, t1c_pkg::ADDR_COUNT, 32'h0000_FFF8);
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (rollover !== 1'h1 && n < 40);
    chk(32'(countValue), 32'h0000_0000);
    chk(32'(rollover), 32'h0000_0001);
    bus(1'h1, 4'hC, 32'h0000_00FF);
    chk(32'(rs), 32'(t1c_pkg::RESP_DECODEERROR));
    bus(1'h0, 4'hC, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    sys_rst <= 1'h1;
    repeat (2) @(posedge clock);
    sys_rst <= 1'h0;
    bus(1'h0, t1c_pkg::ADDR_CONTROL, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    report_and_stop();
  end
endmodule : test_timer1_control_register
`default_nettype wire
